// file: hdl/mbx_core.sv
// branch/bit decoder, dual data pointer and stretched xdata sequencer
`include "mbx_params.svh"
`default_nettype none

// Behaviour
// - carry AND/OR with direct bit, 2/2
// - move bit to carry and back
// - absolute call, 11-bit target, 2/3
// - long call, 16-bit target, 3/4
// - short relative jump, 2/3
// - jump if bit set, clear it
// - jump to accumulator plus pointer
// - jump on accumulator zero/nonzero
// - compare accumulator immediate, jump unequal
// - compare register immediate, jump unequal
// - compare indirect byte immediate, jump unequal
// - decrement and jump if nonzero
// - swap low nibbles accumulator, indirect byte
// - two no-operation opcodes, one cycle
// - stretch field adds 0..7 cycles
// - stretch zero: two cycles, strobe 2
// - stretch seven: nine cycles, strobe 28
// - strobe width four clocks per step
// - stretch field resets to one
// - select bit chooses active pointer
// - pointer users take the selected pointer
// - select writable, increment toggles pointer
module mbx_core
  import mbx_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // instruction decode
  input  wire mbx_dec_in_t  dec_in,
  output var  mbx_dec_out_t dec_out,
  // special function registers
  input  wire mbx_sfr_t     sfr_in,
  output logic [7:0]        sfr_rdata,
  // data pointer control from the core
  input  wire logic         dptr_inc,
  input  wire logic         dptr_load,
  input  wire logic [15:0]  dptr_wdata,
  output logic [15:0]       dptr_active,
  // external data move
  input  wire mbx_xreq_t    xreq,
  output logic              xreq_ready,
  output logic              xdone,
  output logic [7:0]        xrdata,
  // on-chip external data memory
  output logic [15:0]       xram_addr,
  output logic [7:0]        xram_wdata,
  output logic              xram_rd,
  output logic              xram_wr,
  input  wire logic [7:0]   xram_rdata
);

  mbx_state_t   s_q;
  mbx_state_t   s_d;
  mbx_dec_out_t o;
  logic [15:0]  pc_next;
  logic [15:0]  rel_t1;
  logic [15:0]  rel_t2;
  logic [7:0]   dec_r;
  logic [7:0]   dec_d;
  logic [2:0]   stretch;
  logic [15:0]  cur_ptr;
  logic         strobe;

  assign stretch = s_q.ckctl[`MBX_STRETCH_MSB:`MBX_STRETCH_LSB];
  assign cur_ptr = s_q.ptr[s_q.psel];

  mbx_rel_add #(
    .STEP (16'h0002)
  ) i_rel_two (
    .base   (dec_in.pc),
    .offset (dec_in.b1),
    .target (rel_t1)
  );
  mbx_rel_add #(
    .STEP (16'h0003)
  ) i_rel_three (
    .base   (dec_in.pc),
    .offset (dec_in.b2),
    .target (rel_t2)
  );

  // instruction decode
  always_comb begin
    o = '0;
    o.valid = dec_in.valid;
    o.bytes = 2'h1;
    o.cycles = 4'h1;
    pc_next = dec_in.pc + {14'h0000, o.bytes};
    dec_r = dec_in.reg_val - 8'h01;
    dec_d = dec_in.dir_val - 8'h01;
    if (dec_in.op[4:0] == `MBX_ABSOLUTE_CALL_LO) begin
      o.known = 1'b1;
      o.bytes = 2'h2;
      o.cycles = 4'h3;
      o.jump = 1'b1;
      o.call = 1'b1;
    end else if (dec_in.op[7:3] == `MBX_COMPARE_JUMP_UNEQUAL_RN_HI) begin
      o.known = 1'b1;
      o.bytes = 2'h3;
      o.cycles = 4'h4;
      o.jump = dec_in.reg_val != dec_in.b1;
      o.carry_we = 1'b1;
      o.carry = dec_in.reg_val < dec_in.b1;
    end else if (dec_in.op[7:1] == `MBX_COMPARE_JUMP_UNEQUAL_RI_HI) begin
      o.known = 1'b1;
      o.bytes = 2'h3;
      o.cycles = 4'h4;
      o.jump = dec_in.ind_val != dec_in.b1;
      o.carry_we = 1'b1;
      o.carry = dec_in.ind_val < dec_in.b1;
    end else if (dec_in.op[7:3] == `MBX_DECREMENT_JUMP_NONZERO_RN_HI) begin
      o.known = 1'b1;
      o.bytes = 2'h2;
      o.cycles = 4'h3;
      o.reg_we = 1'b1;
      o.reg_val = dec_r;
      o.jump = dec_r != 8'h00;
    end else if (dec_in.op[7:1] == `MBX_NIBBLE_EXCHANGE_HI) begin
      o.known = 1'b1;
      o.acc_we = 1'b1;
      o.ind_we = 1'b1;
      o.acc_val = {dec_in.acc[7:4], dec_in.ind_val[3:0]};
      o.ind_val = {dec_in.ind_val[7:4], dec_in.acc[3:0]};
    end else begin
      unique case (dec_in.op)
        `MBX_OP_NOP, `MBX_OP_NOP_ALT: begin
          o.known = 1'b1;
        end
        `MBX_OP_ANL_C: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h2;
          o.carry_we = 1'b1;
          o.carry = dec_in.carry & dec_in.bit_val;
        end
        `MBX_OP_ANL_NC: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h2;
          o.carry_we = 1'b1;
          o.carry = dec_in.carry & ~dec_in.bit_val;
        end
        `MBX_OP_ORL_C: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h2;
          o.carry_we = 1'b1;
          o.carry = dec_in.carry | dec_in.bit_val;
        end
        `MBX_OP_ORL_NC: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h2;
          o.carry_we = 1'b1;
          o.carry = dec_in.carry | ~dec_in.bit_val;
        end
        `MBX_OP_MOV_CB: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h2;
          o.carry_we = 1'b1;
          o.carry = dec_in.bit_val;
        end
        `MBX_OP_MOV_BC: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h2;
          o.bit_we = 1'b1;
          o.bit_val = dec_in.carry;
        end
        `MBX_OP_LONG_CALL: begin
          o.known = 1'b1;
          o.bytes = 2'h3;
          o.cycles = 4'h4;
          o.jump = 1'b1;
          o.call = 1'b1;
        end
        `MBX_OP_SHORT_JUMP: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h3;
          o.jump = 1'b1;
        end
        `MBX_OP_JBC: begin
          o.known = 1'b1;
          o.bytes = 2'h3;
          o.cycles = 4'h4;
          o.jump = dec_in.bit_val;
          o.bit_we = dec_in.bit_val;
          o.bit_val = 1'b0;
        end
        `MBX_OP_JMP_IND: begin
          o.known = 1'b1;
          o.cycles = 4'h3;
          o.jump = 1'b1;
        end
        `MBX_OP_JZ: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h3;
          o.jump = dec_in.acc == 8'h00;
        end
        `MBX_OP_JNZ: begin
          o.known = 1'b1;
          o.bytes = 2'h2;
          o.cycles = 4'h3;
          o.jump = dec_in.acc != 8'h00;
        end
        `MBX_OP_COMPARE_JUMP_UNEQUAL_AI: begin
          o.known = 1'b1;
          o.bytes = 2'h3;
          o.cycles = 4'h4;
          o.jump = dec_in.acc != dec_in.b1;
          o.carry_we = 1'b1;
          o.carry = dec_in.acc < dec_in.b1;
        end
        `MBX_OP_DECREMENT_JUMP_NONZERO_D: begin
          o.known = 1'b1;
          o.bytes = 2'h3;
          o.cycles = 4'h4;
          o.dir_we = 1'b1;
          o.dir_val = dec_d;
          o.jump = dec_d != 8'h00;
        end
        default: begin
          o.known = 1'b0;
        end
      endcase
    end
    pc_next = dec_in.pc + {14'h0000, o.bytes};
    if (dec_in.op[4:0] == `MBX_ABSOLUTE_CALL_LO) begin
      o.target = {pc_next[15:11], dec_in.op[7:5], dec_in.b1};
    end else if (dec_in.op == `MBX_OP_LONG_CALL) begin
      o.target = {dec_in.b1, dec_in.b2};
    end else if (dec_in.op == `MBX_OP_JMP_IND) begin
      o.target = cur_ptr + {8'h00, dec_in.acc};
    end else if (o.bytes == 2'h3) begin
      o.target = rel_t2;
    end else begin
      o.target = rel_t1;
    end
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.dec = o;
    s_d.xdone = 1'b0;
    // register writes
    if (sfr_in.we) begin
      unique case (sfr_in.addr)
        `MBX_PRIMARY_POINTER_LO_ADDR: s_d.ptr[0][7:0] = sfr_in.wdata;
        `MBX_PRIMARY_POINTER_HI_ADDR: s_d.ptr[0][15:8] = sfr_in.wdata;
        `MBX_SECONDARY_POINTER_LO_ADDR: s_d.ptr[1][7:0] = sfr_in.wdata;
        `MBX_SECONDARY_POINTER_HI_ADDR: s_d.ptr[1][15:8] = sfr_in.wdata;
        `MBX_PSEL_ADDR: s_d.psel = sfr_in.wdata[`MBX_PSEL_BIT];
        `MBX_CKCTL_ADDR: s_d.ckctl = sfr_in.wdata;
        default: s_d.psel = s_q.psel;
      endcase
    end else if (sfr_in.inc && sfr_in.addr == `MBX_PSEL_ADDR) begin
      s_d.psel = ~s_q.psel;
    end
    if (dptr_load) begin
      s_d.ptr[s_q.psel] = dptr_wdata;
    end else if (dptr_inc) begin
      s_d.ptr[s_q.psel] = cur_ptr + 16'h0001;
    end
    unique case (s_q.xst)
      MBX_X_IDLE: begin
        if (xreq.valid) begin
          s_d.xst = MBX_X_RUN;
          s_d.cnt = 6'h00;
          s_d.xlen = (`MBX_XD_BASE_ICYC + {3'h0, stretch})
                     * `MBX_CLK_PER_ICYC;
          s_d.xstb = (stretch == 3'h0) ? `MBX_STB_W0
                     : `MBX_STB_W_STEP * {3'h0, stretch};
          s_d.xwr = xreq.wr;
          s_d.xaddr = xreq.wide ? cur_ptr : {8'h00, xreq.addr8};
          s_d.xwdata = xreq.wdata;
        end
      end
      MBX_X_RUN: begin
        s_d.cnt = s_q.cnt + 6'h01;
        if (strobe && !s_q.xwr &&
            s_q.cnt == `MBX_STB_START + s_q.xstb - 6'h01) begin
          s_d.xrdata = xram_rdata;
        end
        if (s_q.cnt == s_q.xlen - 6'h01) begin
          s_d.xst = MBX_X_IDLE;
          s_d.xdone = 1'b1;
        end
      end
      default: s_d.xst = MBX_X_IDLE;
    endcase
    // register reads
    unique case (sfr_in.addr)
      `MBX_PRIMARY_POINTER_LO_ADDR: s_d.sfr_rdata = s_q.ptr[0][7:0];
      `MBX_PRIMARY_POINTER_HI_ADDR: s_d.sfr_rdata = s_q.ptr[0][15:8];
      `MBX_SECONDARY_POINTER_LO_ADDR: s_d.sfr_rdata = s_q.ptr[1][7:0];
      `MBX_SECONDARY_POINTER_HI_ADDR: s_d.sfr_rdata = s_q.ptr[1][15:8];
      `MBX_PSEL_ADDR:     s_d.sfr_rdata = {7'h00, s_q.psel};
      `MBX_CKCTL_ADDR:    s_d.sfr_rdata = s_q.ckctl;
      default:            s_d.sfr_rdata = 8'h00;
    endcase
  end

  // strobe window inside the access
  assign strobe = (s_q.xst == MBX_X_RUN) && (s_q.cnt >= `MBX_STB_START)
                  && (s_q.cnt < `MBX_STB_START + s_q.xstb);

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.ptr <= {`MBX_DPTR_RST, `MBX_DPTR_RST};
      s_q.psel <= `MBX_PSEL_RST;
      s_q.ckctl <= `MBX_CKCTL_RST;
      s_q.xst <= MBX_X_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign dec_out     = s_q.dec;
  assign sfr_rdata   = s_q.sfr_rdata;
  assign dptr_active = cur_ptr;
  assign xreq_ready  = s_q.xst == MBX_X_IDLE;
  assign xdone       = s_q.xdone;
  assign xrdata      = s_q.xrdata;
  assign xram_addr   = s_q.xaddr;
  assign xram_wdata  = s_q.xwdata;
  assign xram_rd     = strobe && !s_q.xwr;
  assign xram_wr     = strobe && s_q.xwr;

endmodule

// branch target: opcode address plus length plus signed offset
module mbx_rel_add #(
  parameter logic [15:0] STEP = 16'h0002
) (
  // opcode address and offset
  input  wire logic [15:0] base,
  input  wire logic [7:0]  offset,
  // resulting target
  output logic [15:0]      target
);
  assign target = base + STEP + {{8{offset[7]}}, offset};
endmodule
`default_nettype wire

// file: hdl/mbx_params.svh
// constants for the branch, bit-op, pointer and xdata stretch block
`ifndef MBX_PARAMS_SVH
`define MBX_PARAMS_SVH

// special function register offsets
`define MBX_PRIMARY_POINTER_LO_ADDR 8'h82
`define MBX_PRIMARY_POINTER_HI_ADDR 8'h83
`define MBX_SECONDARY_POINTER_LO_ADDR 8'h84
`define MBX_SECONDARY_POINTER_HI_ADDR 8'h85
`define MBX_PSEL_ADDR     8'h86
`define MBX_CKCTL_ADDR    8'h8E

// reset values
`define MBX_CKCTL_RST     8'h01
`define MBX_PSEL_RST      1'h0
`define MBX_DPTR_RST      16'h0000

// field positions
`define MBX_PSEL_BIT      0
`define MBX_STRETCH_MSB   2
`define MBX_STRETCH_LSB   0

// stretched access timing, in clocks; the base length MBX_XD_BASE_ICYC is in instruction cycles
`define MBX_CLK_PER_ICYC  6'h04
`define MBX_XD_BASE_ICYC  6'h02
`define MBX_STB_START     6'h04
`define MBX_STB_W0        6'h02
`define MBX_STB_W_STEP    6'h04

// opcodes
`define MBX_OP_NOP        8'h00
`define MBX_OP_NOP_ALT    8'hA5
`define MBX_OP_ANL_C      8'h82
`define MBX_OP_ANL_NC     8'hB0
`define MBX_OP_ORL_C      8'h72
`define MBX_OP_ORL_NC     8'hA0
`define MBX_OP_MOV_CB     8'hA2
`define MBX_OP_MOV_BC     8'h92
`define MBX_OP_LONG_CALL      8'h12
`define MBX_OP_SHORT_JUMP       8'h80
`define MBX_OP_JBC        8'h10
`define MBX_OP_JMP_IND    8'h73
`define MBX_OP_JZ         8'h60
`define MBX_OP_JNZ        8'h70
`define MBX_OP_COMPARE_JUMP_UNEQUAL_AI    8'hB4
`define MBX_OP_DECREMENT_JUMP_NONZERO_D     8'hD5
`define MBX_ABSOLUTE_CALL_LO      5'h11
`define MBX_COMPARE_JUMP_UNEQUAL_RN_HI    5'h17
`define MBX_COMPARE_JUMP_UNEQUAL_RI_HI    7'h5B
`define MBX_DECREMENT_JUMP_NONZERO_RN_HI    5'h1B
`define MBX_NIBBLE_EXCHANGE_HI       7'h6B

`endif

// file: hdl/mbx_pkg.sv
// types for the branch, bit-op, pointer and xdata stretch block
`default_nettype none
package mbx_pkg;

  typedef enum logic [1:0] {
    MBX_X_IDLE = 2'b01,
    MBX_X_RUN  = 2'b10
  } mbx_xstate_t;

  // one instruction with its fetched operands and sampled sources
  typedef struct packed {
    logic        valid;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic        carry;
    logic        bit_val;
    logic [7:0]  reg_val;
    logic [7:0]  dir_val;
    logic [7:0]  ind_val;
  } mbx_dec_in_t;

  // decoded effects of one instruction
  typedef struct packed {
    logic        valid;
    logic        known;
    logic [1:0]  bytes;
    logic [3:0]  cycles;
    logic        jump;
    logic        call;
    logic [15:0] target;
    logic        carry_we;
    logic        carry;
    logic        bit_we;
    logic        bit_val;
    logic        reg_we;
    logic        dir_we;
    logic        ind_we;
    logic        acc_we;
    logic [7:0]  reg_val;
    logic [7:0]  dir_val;
    logic [7:0]  ind_val;
    logic [7:0]  acc_val;
  } mbx_dec_out_t;

  // external data move request from the core
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        wide;
    logic [7:0]  addr8;
    logic [7:0]  wdata;
  } mbx_xreq_t;

  // special function register access
  typedef struct packed {
    logic        we;
    logic        inc;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } mbx_sfr_t;

  typedef struct packed {
    logic [1:0][15:0] ptr;
    logic             psel;
    logic [7:0]       ckctl;
    mbx_dec_out_t     dec;
    mbx_xstate_t      xst;
    logic [5:0]       cnt;
    logic [5:0]       xlen;
    logic [5:0]       xstb;
    logic             xwr;
    logic [15:0]      xaddr;
    logic [7:0]       xwdata;
    logic [7:0]       xrdata;
    logic             xdone;
    logic [7:0]       sfr_rdata;
  } mbx_state_t;

endpackage
`default_nettype wire

// file: testbench/mbx_core_assertions.sv
// concurrent checks on the decoder and stretched access
`include "mbx_params.svh"
`default_nettype none
module mbx_core_chk
  import mbx_pkg::*;
(
  // clock and reset
  input wire logic         clock,
  input wire logic         rst,
  // decoder and registers
  input wire mbx_dec_in_t  dec_in,
  input wire mbx_dec_out_t dec_out,
  input wire mbx_sfr_t     sfr_in,
  // external data move
  input wire mbx_xreq_t    xreq,
  input wire logic         xreq_ready,
  input wire logic         xdone,
  input wire logic         xram_rd,
  input wire logic         xram_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] st_q;
  logic [2:0] n_q;
  logic [5:0] acnt_q;
  logic [5:0] sw_q;
  logic       busy_q;
  logic       stb;
  logic [5:0] wd;
  logic [5:0] cyc;
  assign stb = xram_rd | xram_wr;
  assign wd  = (n_q == 3'h0) ? 6'h02 : {1'b0, n_q, 2'b00};
  assign cyc = {1'b0, n_q, 2'b00} + 6'h08;
  // stretch shadow, access and strobe counters
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q   <= 3'h1;
      n_q    <= 3'h0;
      acnt_q <= 6'h00;
      sw_q   <= 6'h00;
      busy_q <= 1'b0;
    end else begin
      if (sfr_in.we && sfr_in.addr == `MBX_CKCTL_ADDR) begin
        st_q <= sfr_in.wdata[2:0];
      end
      if (xdone) busy_q <= 1'b0;
      if (busy_q) acnt_q <= acnt_q + 6'h01;
      if (xreq.valid && xreq_ready) begin
        n_q    <= st_q;
        acnt_q <= 6'h00;
        busy_q <= 1'b1;
      end
      sw_q <= stb ? sw_q + 6'h01 : 6'h00;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_nop_single: assert property (dec_in.valid && (dec_in.op == 8'h00 ||
    dec_in.op == 8'hA5) |=> dec_out.known && dec_out.cycles == 4'h1 &&
    dec_out.bytes == 2'h1 && !dec_out.jump) else $error("nop decode bad");
  a_short_jump: assert property (dec_in.valid && dec_in.op == 8'h80 |=>
    dec_out.jump && dec_out.target == $past(dec_in.pc) + 16'h0002 +
    {{8{$past(dec_in.b1[7])}}, $past(dec_in.b1)}) else $error("short_jump bad");
  a_long_call: assert property (dec_in.valid && dec_in.op == 8'h12 |=>
    dec_out.call && dec_out.cycles == 4'h4 && dec_out.target ==
    {$past(dec_in.b1), $past(dec_in.b2)}) else $error("long call bad");
  a_abs_call: assert property (dec_in.valid && dec_in.op[4:0] == 5'h11 |=>
    dec_out.call && dec_out.bytes == 2'h2 && dec_out.target[10:0] ==
    {$past(dec_in.op[7:5]), $past(dec_in.b1)}) else $error("abs call bad");
  a_acc_zero: assert property (dec_in.valid && (dec_in.op == 8'h60 ||
    dec_in.op == 8'h70) |=> dec_out.jump == (($past(dec_in.acc) == 8'h00)
    ^ $past(dec_in.op[4]))) else $error("acc branch bad");
  a_bit_clear: assert property (dec_in.valid && dec_in.op == 8'h10 &&
    dec_in.bit_val |=> dec_out.jump && dec_out.bit_we && !dec_out.bit_val)
    else $error("bit jump clear bad");
  a_decrement_jump_nonzero_reg: assert property (dec_in.valid &&
    dec_in.op[7:3] == `MBX_DECREMENT_JUMP_NONZERO_RN_HI |=> dec_out.reg_we &&
    dec_out.reg_val == $past(dec_in.reg_val) - 8'h01 &&
    dec_out.jump == ($past(dec_in.reg_val) != 8'h01)) else $error("decrement_jump_nonzero bad");
  a_nibble_swap: assert property (dec_in.valid &&
    dec_in.op[7:1] == `MBX_NIBBLE_EXCHANGE_HI |=> dec_out.acc_val ==
    {$past(dec_in.acc[7:4]), $past(dec_in.ind_val[3:0])} && dec_out.ind_val
    == {$past(dec_in.ind_val[7:4]), $past(dec_in.acc[3:0])})
    else $error("nibble swap bad");
  a_access_len: assert property (xdone |->
    busy_q && acnt_q == cyc) else $error("access length bad");
  a_strobe_width: assert property ($fell(stb) |-> sw_q == wd)
    else $error("strobe width bad");
  a_busy_refuse: assert property (xreq.valid && xreq_ready |=>
    !xreq_ready [*7]) else $error("ready during access");
  a_ready_back: assert property (xdone |-> xreq_ready)
    else $error("not ready at done");
  cover property (xdone && n_q == 3'h7);
  cover property ($fell(stb) && n_q == 3'h0);
  cover property (dec_in.valid && dec_in.op == 8'h73);
endmodule
bind mbx_core mbx_core_chk i_mbx_core_chk (.clock, .rst, .dec_in, .dec_out,
  .sfr_in, .xreq, .xreq_ready, .xdone, .xram_rd, .xram_wr);
`default_nettype wire

// file: testbench/mbx_xram_model.sv
// behavioural on-chip data memory behind the stretched strobes
`default_nettype none
module mbx_xram_model (
  // clock
  input  wire logic        clock,
  // strobed access
  input  wire logic [15:0] xram_addr,
  input  wire logic [7:0]  xram_wdata,
  input  wire logic        xram_rd,
  input  wire logic        xram_wr,
  output logic [7:0]       xram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  always @(posedge clock) begin
    if (xram_wr) mem[xram_addr[7:0]] <= xram_wdata;
    if (xram_rd) last_q <= mem[xram_addr[7:0]];
  end
  // idle bus shows the inverse of the last value
  assign xram_rdata = xram_rd ? mem[xram_addr[7:0]] : ~last_q;
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the decoder, pointers and stretched access
`default_nettype none
module tb
  import mbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  mbx_dec_in_t  dec_in = '0;
  mbx_dec_out_t dec_out;
  mbx_sfr_t     sfr_in = '0;
  mbx_xreq_t    xreq = '0;
  logic         dptr_inc = 1'b0;
  logic         dptr_load = 1'b0;
  logic [15:0]  dptr_wdata = 16'h0000;
  logic [15:0]  dptr_active;
  logic [15:0]  xram_addr;
  logic         xreq_ready;
  logic         xdone;
  logic         xram_rd;
  logic         xram_wr;
  logic [7:0]   sfr_rdata;
  logic [7:0]   xrdata;
  logic [7:0]   xram_wdata;
  logic [7:0]   xram_rdata;
  logic [7:0]   rd;
  logic [35:0]  e;
  int           fail_count = 0;
  int           checks = 0;
  // op, bytes/cycles, flags jm jp cm cv, target (0 = not checked)
  logic [35:0] tv [22] = '{
    36'h8222A0000, 36'h7222B0000, 36'hA022A0000,
    36'hA222B0000, 36'h922280000,
    36'h112300005, 36'hF12300705, 36'h1234005FE,
    36'h8023C0107, 36'h1034C0101, 36'h7313C1235,
    36'h6023C0107, 36'h702380000, 36'hB434C0101,
    36'hB834C0101, 36'hB63480000, 36'hD82380000,
    36'hD534C0101, 36'hD61100000, 36'h001180000,
    36'hA51180000, 36'hB022A0000};
  always #2 clock = ~clock;
  mbx_core i_mbx_core (.clock, .rst, .dec_in, .dec_out, .sfr_in, .sfr_rdata,
    .dptr_inc, .dptr_load, .dptr_wdata, .dptr_active, .xreq, .xreq_ready,
    .xdone, .xrdata, .xram_addr, .xram_wdata, .xram_rd, .xram_wr,
    .xram_rdata);
  mbx_xram_model i_mbx_xram_model (.clock, .xram_addr, .xram_wdata,
    .xram_rd, .xram_wr, .xram_rdata);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic sfr_op(input logic inc, input logic [7:0] a, d);
    @(posedge clock);
    sfr_in <= '{we: ~inc, inc: inc, addr: a, wdata: d};
    @(posedge clock);
    sfr_in.we <= 1'b0;
    sfr_in.inc <= 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_in.addr <= a;
    @(posedge clock);
    #1 d = sfr_rdata;
  endtask
  task automatic ptr_pulse(input logic ld, input logic [15:0] w);
    @(posedge clock);
    dptr_load <= ld;
    dptr_inc <= ~ld;
    dptr_wdata <= w;
    @(posedge clock);
    dptr_load <= 1'b0;
    dptr_inc <= 1'b0;
    #1;
  endtask
  task automatic xmove(input logic wr, wide, input logic [7:0] a, wd,
                       input int cyc, output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clock);
    xreq <= '{valid: 1'b1, wr: wr, wide: wide, addr8: a, wdata: wd};
    @(posedge clock);
    xreq.valid <= 1'b0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (xdone !== 1'b1 && k < 60);
    `CHK("access cycles", cyc, k)
    if (k >= 60) complete_run;
    else r = xrdata;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    sfr_rd(8'h8E, rd); `CHK("clock control", 8'h01, rd)
    sfr_rd(8'h86, rd); `CHK("select", 8'h00, rd)
    sfr_rd(8'h82, rd); `CHK("pointer low", 8'h00, rd)
    sfr_rd(8'h9F, rd); `CHK("unmapped", 8'h00, rd)
    $display("test reset values done");
    sfr_op(0, 8'h82, 8'h34);
    sfr_op(0, 8'h83, 8'h12);
    sfr_op(0, 8'h84, 8'h78);
    sfr_op(0, 8'h85, 8'h56);
    #1 `CHK("active", 16'h1234, dptr_active)
    sfr_op(0, 8'h86, 8'h01); #1 `CHK("active", 16'h5678, dptr_active)
    ptr_pulse(1, 16'h4321); `CHK("active", 16'h4321, dptr_active)
    sfr_rd(8'h84, rd); `CHK("pointer1 low", 8'h21, rd)
    sfr_op(1, 8'h86, 8'h00); #1 `CHK("active", 16'h1234, dptr_active)
    ptr_pulse(0, 16'h0000); `CHK("active", 16'h1235, dptr_active)
    sfr_rd(8'h86, rd); `CHK("select", 8'h00, rd)
    $display("test pointers done");
    for (int i = 0; i < 22; i++) begin
      e = tv[i];
      @(posedge clock);
      dec_in <= '{1'h1, e[35:28], 8'h05, 8'hFE, 16'h0100, 8'h00, 1'h0,
                  1'h1, 8'h01, 8'h03, 8'h05};
      @(posedge clock);
      #1 `CHK("known", 1'h1, dec_out.known)
      `CHK("bytes", e[25:24], dec_out.bytes)
      `CHK("cycles", e[23:20], dec_out.cycles)
      if (e[19]) `CHK("jump", e[18], dec_out.jump)
      if (e[17]) `CHK("carry", e[16], dec_out.carry)
      if (e[15:0] != 16'h0000) `CHK("target", e[15:0], dec_out.target)
    end
    @(posedge clock);
    dec_in <= '0;
    $display("test decode done");
    for (int n = 0; n < 8; n++) begin
      sfr_op(0, 8'h8E, 8'(n));
      xmove(1, 0, 8'(8'h10 + n), 8'(8'hA0 + n), (2 + n) * 4, rd);
      xmove(0, 0, 8'(8'h10 + n), 8'h00, (2 + n) * 4, rd);
      `CHK("read back", 8'(8'hA0 + n), rd)
    end
    xmove(1, 1, 8'h00, 8'h5A, 36, rd);
    xmove(0, 1, 8'h00, 8'h00, 36, rd); `CHK("wide read", 8'h5A, rd)
    `CHK("wide addr", 8'h5A, i_mbx_xram_model.mem[8'h35])
    $display("test stretch done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    sfr_rd(8'h8E, rd); `CHK("clock control", 8'h01, rd)
    xmove(0, 0, 8'h10, 8'h00, 12, rd); `CHK("read", 8'hA0, rd)
    $display("test second reset done");
    complete_run;
  end
endmodule
`default_nettype wire
